// File: exec_pkg.sv
// Package for the file-register execution datapath: opcodes, fields, widths, reset values.
// Assumes a 14-bit instruction word in the mid-range encoding and a 13-bit program counter.
package exec_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int BRANCH_W = 11;
  localparam int LATCH_W = 5;
  // Field positions: destination bit of the instruction word, page bits of the pc upper latch.
  localparam int DEST_BIT = 7;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  // Reset values and arithmetic constants.
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // Byte-oriented opcodes, instruction bits 13:8.
  localparam logic [5:0] OP_IOR_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE = 6'h08;
  localparam logic [5:0] OP_INC_FILE = 6'h0A;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  // Move accumulator to file: bits 13:7 are 0000001.
  localparam logic [6:0] OP_MOVE_ACC = 7'h01;
  // Branch: bits 13:11 are 101.
  localparam logic [2:0] OP_BRANCH = 3'h5;
  // Literal ops, bits 13:10 (move-literal) and 13:8 (or-literal).
  localparam logic [3:0] OP_MOVE_LIT = 4'hC;
  localparam logic [5:0] OP_IOR_LIT = 6'h38;

  typedef enum logic [3:0] {
    OPC_NONE, OPC_DEC_SKIP, OPC_INC_SKIP, OPC_INC, OPC_BRANCH,
    OPC_IOR_LIT, OPC_IOR_FILE, OPC_MOVE_FILE, OPC_MOVE_LIT, OPC_MOVE_ACC
  } opclass_e;

  // Decoded instruction carried from the decoder to the core.
  typedef struct packed {
    opclass_e op;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] lit;
    logic [BRANCH_W-1:0] target;
  } decoded_s;

  // File write request toward the data memory.
  typedef struct packed {
    logic we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fwrite_s;
endpackage : exec_pkg

// File: insn_decode.sv
// Instruction decoder: splits a 14-bit word into operation class and operand fields.
// Purely combinational; sits in the same clock domain as the core.
`timescale 1ns/1ps
`default_nettype none
module insn_decode (
  input wire logic [exec_pkg::INSN_W-1:0] insn,
  output exec_pkg::decoded_s dec
);
  // Match the opcode fields; anything outside the subset decodes as no operation.
  always_comb
  begin
    dec = '0;
    dec.dest_file = insn[exec_pkg::DEST_BIT];
    dec.faddr = insn[exec_pkg::FADDR_W-1:0];
    dec.lit = insn[exec_pkg::DATA_W-1:0];
    dec.target = insn[exec_pkg::BRANCH_W-1:0];
    dec.op = exec_pkg::OPC_NONE;
    if (insn[13:11] == exec_pkg::OP_BRANCH)
      dec.op = exec_pkg::OPC_BRANCH;
    else if (insn[13:10] == exec_pkg::OP_MOVE_LIT)
      dec.op = exec_pkg::OPC_MOVE_LIT;
    else if (insn[13:8] == exec_pkg::OP_IOR_LIT)
      dec.op = exec_pkg::OPC_IOR_LIT;
    else if (insn[13:7] == exec_pkg::OP_MOVE_ACC)
      dec.op = exec_pkg::OPC_MOVE_ACC;
    else
    begin
      case (insn[13:8])
        exec_pkg::OP_IOR_FILE: dec.op = exec_pkg::OPC_IOR_FILE;
        exec_pkg::OP_MOVE_FILE: dec.op = exec_pkg::OPC_MOVE_FILE;
        exec_pkg::OP_INC_FILE: dec.op = exec_pkg::OPC_INC;
        exec_pkg::OP_DEC_SKIP: dec.op = exec_pkg::OPC_DEC_SKIP;
        exec_pkg::OP_INC_SKIP: dec.op = exec_pkg::OPC_INC_SKIP;
        default: dec.op = exec_pkg::OPC_NONE;
      endcase
    end
  end
endmodule : insn_decode
`default_nettype wire

// File: alu8.sv
// Eight-bit arithmetic unit: result and zero test for the supported operations.
// Combinational; operands arrive already selected by the core.
`timescale 1ns/1ps
`default_nettype none
module alu8 (
  input wire exec_pkg::opclass_e op,
  input wire logic [exec_pkg::DATA_W-1:0] acc,
  input wire logic [exec_pkg::DATA_W-1:0] fval,
  input wire logic [exec_pkg::DATA_W-1:0] lit,
  output logic [exec_pkg::DATA_W-1:0] result,
  output logic zero
);
  // Wrap-around arithmetic is intended: 0xFF plus one gives zero and so a skip.
  always_comb
  begin
    case (op)
      exec_pkg::OPC_DEC_SKIP: result = fval - exec_pkg::ONE;
      exec_pkg::OPC_INC_SKIP, exec_pkg::OPC_INC: result = fval + exec_pkg::ONE;
      exec_pkg::OPC_IOR_LIT: result = acc | lit;
      exec_pkg::OPC_IOR_FILE: result = acc | fval;
      exec_pkg::OPC_MOVE_FILE: result = fval;
      exec_pkg::OPC_MOVE_LIT: result = lit;
      exec_pkg::OPC_MOVE_ACC: result = acc;
      default: result = exec_pkg::ZERO_BYTE;
    endcase
    zero = (result == exec_pkg::ZERO_BYTE);
  end
endmodule : alu8
`default_nettype wire

// File: file_exec_core.sv
// Execution core for a subset of file-register instructions, one instruction per mclk cycle; a branch or a taken skip adds a discarded slot.
// Assumes the fetch side presents insn with insn_valid, and the data file answers fread
// combinationally for the address on faddr in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module file_exec_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [exec_pkg::INSN_W-1:0] insn,
  input wire logic insn_valid,
  input wire logic [exec_pkg::LATCH_W-1:0] pc_upper_latch,
  input wire logic [exec_pkg::DATA_W-1:0] fread,
  output logic [exec_pkg::FADDR_W-1:0] faddr,
  output exec_pkg::fwrite_s fwrite,
  output logic [exec_pkg::PC_W-1:0] pc,
  output logic [exec_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  output logic flush
);
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_FLUSH = 2'b01
  } slot_e;

  exec_pkg::decoded_s dec;
  logic [exec_pkg::DATA_W-1:0] result;
  logic res_zero;
  slot_e slot_r, slot_nxt;
  logic [exec_pkg::PC_W-1:0] pc_r, pc_nxt;
  logic [exec_pkg::DATA_W-1:0] acc_r, acc_nxt;
  logic zero_r, zero_nxt;
  exec_pkg::fwrite_s fw_r, fw_nxt;
  logic run;

  insn_decode insn_decode_inst (
    .insn(insn),
    .dec(dec)
  );

  alu8 alu8_inst (
    .op(dec.op),
    .acc(acc_r),
    .fval(fread),
    .lit(dec.lit),
    .result(result),
    .zero(res_zero)
  );

  // True for operations whose result may go to either the file or the accumulator.
  function automatic logic has_dest(input exec_pkg::opclass_e op);
    has_dest = (op == exec_pkg::OPC_DEC_SKIP) || (op == exec_pkg::OPC_INC_SKIP) ||
               (op == exec_pkg::OPC_INC) || (op == exec_pkg::OPC_IOR_FILE) ||
               (op == exec_pkg::OPC_MOVE_FILE);
  endfunction : has_dest

  // True for operations that update the zero flag.
  function automatic logic sets_zero(input exec_pkg::opclass_e op);
    sets_zero = (op == exec_pkg::OPC_INC) || (op == exec_pkg::OPC_IOR_LIT) ||
                (op == exec_pkg::OPC_IOR_FILE) || (op == exec_pkg::OPC_MOVE_FILE);
  endfunction : sets_zero

  assign run = insn_valid && (slot_r == ST_EXEC);
  assign faddr = dec.faddr;

  // Next-state logic; the flush slot discards whatever word is presented, which is
  // how both the skip and the second branch cycle are realised.
  always_comb
  begin
    slot_nxt = ST_EXEC;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    fw_nxt = '0;
    if (slot_r == ST_FLUSH)
    begin
      slot_nxt = ST_EXEC; // The discarded slot costs the second cycle.
    end
    else if (run)
    begin
      pc_nxt = pc_r + exec_pkg::PC_STEP;
      case (dec.op)
        exec_pkg::OPC_BRANCH:
        begin
          pc_nxt = {pc_upper_latch[exec_pkg::LATCH_HI:exec_pkg::LATCH_LO], dec.target};
          slot_nxt = ST_FLUSH;
        end
        exec_pkg::OPC_DEC_SKIP, exec_pkg::OPC_INC_SKIP:
        begin
          if (res_zero)
            slot_nxt = ST_FLUSH;
        end
        exec_pkg::OPC_IOR_LIT, exec_pkg::OPC_MOVE_LIT:
          acc_nxt = result;
        exec_pkg::OPC_MOVE_ACC:
        begin
          fw_nxt.we = 1'b1;
          fw_nxt.addr = dec.faddr;
          fw_nxt.data = acc_r;
        end
        default:
        begin
        end
      endcase
      // Destination routing shared by all byte ops.
      if (has_dest(dec.op))
      begin
        if (dec.dest_file)
        begin
          fw_nxt.we = 1'b1;
          fw_nxt.addr = dec.faddr;
          fw_nxt.data = result;
        end
        else
          acc_nxt = result;
      end
      if (sets_zero(dec.op))
        zero_nxt = res_zero;
    end
  end

  // State registers only.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_r <= ST_EXEC;
      pc_r <= exec_pkg::PC_RESET;
      acc_r <= exec_pkg::ACC_RESET;
      zero_r <= 1'b0;
      fw_r <= '0;
    end
    else
    begin
      slot_r <= slot_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
      fw_r <= fw_nxt;
    end
  end

  assign pc = pc_r;
  assign acc = acc_r;
  assign zero_flag = zero_r;
  assign fwrite = fw_r;
  assign flush = (slot_r == ST_FLUSH);

  // A zero decrement result must discard exactly the next slot.
  a_dec_skip_zero: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_DEC_SKIP && fread == exec_pkg::ONE
    |=> flush ##1 !flush)
    else $error("decrement to zero did not skip one slot");

  // Decrement-skip leaves the zero flag alone.
  a_dec_no_flags: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_DEC_SKIP |=> $stable(zero_flag))
    else $error("decrement-skip changed the zero flag");

  // Increment-skip skips on wrap to zero and never when nonzero.
  a_inc_skip_cond: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_INC_SKIP |=> flush == ($past(fread) == 8'hFF))
    else $error("increment-skip skip decision wrong");

  // Destination bit picks accumulator or file write.
  a_dest_route: assert property (@(posedge mclk) disable iff (!rstn)
    run && has_dest(dec.op) |=> fwrite.we == $past(dec.dest_file))
    else $error("destination routing wrong");

  // Increment to accumulator delivers file plus one and its zero test.
  a_inc_result: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_INC && !dec.dest_file
    |=> acc == $past(fread) + exec_pkg::ONE && zero_flag == (acc == 8'h00))
    else $error("increment result or zero flag wrong");

  // Branch target and two-cycle timing.
  a_branch_pc: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_BRANCH
    |=> pc == {$past(pc_upper_latch[4:3]), $past(dec.target)} && flush ##1 !flush)
    else $error("branch target or timing wrong");

  // Or-literal result and zero flag.
  a_ior_literal: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_IOR_LIT
    |=> acc == ($past(acc) | $past(dec.lit)) && zero_flag == (acc == 8'h00))
    else $error("or-literal result wrong");

  // Or-file written back to the file.
  a_ior_file: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_IOR_FILE && dec.dest_file
    |=> fwrite.data == ($past(acc) | $past(fread)))
    else $error("or-file result wrong");

  // Move-file zero flag follows the moved value.
  a_move_zero: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_MOVE_FILE |=> zero_flag == ($past(fread) == 8'h00))
    else $error("move-file zero flag wrong");

  // Move-literal loads accumulator, flags stay.
  a_move_literal: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_MOVE_LIT
    |=> acc == $past(dec.lit) && $stable(zero_flag))
    else $error("move-literal wrong");

  // Move-acc writes the file at the given address.
  a_move_acc: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_MOVE_ACC
    |=> fwrite.we && fwrite.addr == $past(dec.faddr) && fwrite.data == $past(acc))
    else $error("move-acc write wrong");

  // Plain one-cycle ops advance the pc by one with no flush.
  a_single_step: assert property (@(posedge mclk) disable iff (!rstn)
    run && (dec.op == exec_pkg::OPC_MOVE_LIT || dec.op == exec_pkg::OPC_NONE)
    |=> !flush && pc == $past(pc) + exec_pkg::PC_STEP)
    else $error("single-cycle op did not step pc by one");

  // Decrement-skip into the accumulator delivers file minus one.
  a_dec_acc_result: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_DEC_SKIP && !dec.dest_file
    |=> acc == $past(fread) - exec_pkg::ONE && !fwrite.we)
    else $error("decrement-skip accumulator result wrong");

  // Decrement-skip back into the file writes file minus one at the same address.
  a_dec_file_write: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_DEC_SKIP && dec.dest_file
    |=> fwrite.we && fwrite.addr == $past(dec.faddr)
    && fwrite.data == $past(fread) - exec_pkg::ONE)
    else $error("decrement-skip file write wrong");

  // A nonzero decrement result must not discard the next slot.
  a_dec_no_skip: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_DEC_SKIP && fread != exec_pkg::ONE |=> !flush)
    else $error("decrement-skip skipped on a nonzero result");

  // Increment-skip leaves the zero flag alone.
  a_inc_skip_flags: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_INC_SKIP |=> $stable(zero_flag))
    else $error("increment-skip changed the zero flag");

  // Increment-skip back into the file writes file plus one and keeps the accumulator.
  a_inc_skip_file: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_INC_SKIP && dec.dest_file
    |=> fwrite.data == $past(fread) + exec_pkg::ONE && $stable(acc))
    else $error("increment-skip file result wrong");

  // A file destination must leave the accumulator untouched.
  a_dest_acc_hold: assert property (@(posedge mclk) disable iff (!rstn)
    run && has_dest(dec.op) && dec.dest_file |=> $stable(acc))
    else $error("file destination disturbed the accumulator");

  // Increment back into the file writes file plus one and sets zero from it.
  a_inc_file_write: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_INC && dec.dest_file
    |=> fwrite.data == $past(fread) + exec_pkg::ONE
    && zero_flag == (fwrite.data == exec_pkg::ZERO_BYTE))
    else $error("increment file result or zero flag wrong");

  // A branch touches neither flags, accumulator nor the file.
  a_branch_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_BRANCH
    |=> $stable(zero_flag) && $stable(acc) && !fwrite.we)
    else $error("branch disturbed data state");

  // Literal ops never write the file.
  a_lit_no_write: assert property (@(posedge mclk) disable iff (!rstn)
    run && (dec.op == exec_pkg::OPC_IOR_LIT || dec.op == exec_pkg::OPC_MOVE_LIT)
    |=> !fwrite.we)
    else $error("literal op wrote the file");

  // Or-file into the accumulator and its zero flag.
  a_ior_file_acc: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_IOR_FILE && !dec.dest_file
    |=> acc == ($past(acc) | $past(fread)) && zero_flag == (acc == exec_pkg::ZERO_BYTE))
    else $error("or-file accumulator result wrong");

  // Move-file into the accumulator copies the file value.
  a_move_file_acc: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_MOVE_FILE && !dec.dest_file
    |=> acc == $past(fread) && !fwrite.we)
    else $error("move-file accumulator result wrong");

  // Move-acc leaves flags and accumulator as they were.
  a_move_acc_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    run && dec.op == exec_pkg::OPC_MOVE_ACC |=> $stable(zero_flag) && $stable(acc))
    else $error("move-acc changed flags or accumulator");

  // A stall outside the discarded slot changes nothing, so fetch may pause in any execute slot.
  a_stall_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !insn_valid && !flush |=> $stable(pc) && $stable(acc) && !fwrite.we)
    else $error("stall changed core state");

  // The discarded slot behaves as a no-op that does not move the pc.
  a_flush_hold: assert property (@(posedge mclk) disable iff (!rstn)
    flush |=> $stable(pc) && $stable(acc) && $stable(zero_flag) && !fwrite.we)
    else $error("discarded slot changed core state");

  // The remaining one-cycle ops step the pc by one with no discarded slot.
  a_step_pc: assert property (@(posedge mclk) disable iff (!rstn)
    run && (dec.op == exec_pkg::OPC_INC || dec.op == exec_pkg::OPC_IOR_LIT ||
    dec.op == exec_pkg::OPC_IOR_FILE || dec.op == exec_pkg::OPC_MOVE_FILE ||
    dec.op == exec_pkg::OPC_MOVE_ACC)
    |=> !flush && pc == $past(pc) + exec_pkg::PC_STEP)
    else $error("one-cycle op did not step pc by one");
endmodule : file_exec_core
`default_nettype wire

// File: file_exec_core_test.sv
// Self-checking bench for the file-register execution core.
// Assumes the core answers one cycle after each taken word; the data file is modelled here.
`timescale 1ns/1ps
`default_nettype none
module file_exec_core_test;
  logic mclk, rstn, insn_valid, taken, zero_flag, flush, z_m;
  logic [13:0] insn;
  logic [4:0] pc_upper_latch;
  logic [7:0] fread, acc, acc_m;
  logic [6:0] faddr;
  logic [12:0] pc, pc_m;
  logic [38:0] note;
  exec_pkg::fwrite_s fwrite;
  logic [7:0] fmem [128];
  logic [38:0] notes [$];
  int error_cnt, samples_checked, seed, i;

  // The data file answers combinationally, as the core expects.
  assign fread = fmem[faddr];

  file_exec_core file_exec_core_inst (.mclk(mclk), .rstn(rstn), .insn(insn),
    .insn_valid(insn_valid), .pc_upper_latch(pc_upper_latch), .fread(fread),
    .faddr(faddr), .fwrite(fwrite), .pc(pc), .acc(acc), .zero_flag(zero_flag),
    .flush(flush));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Old flush is read here, so a word shown in a flush slot is never counted as taken.
  always @(posedge mclk) taken <= rstn && insn_valid && !flush;

  // Each taken word owes exactly one note; the oldest is compared a half cycle later.
  always @(negedge mclk)
  begin
    if (taken && notes.size() > 0)
    begin
      note = notes.pop_front();
      check("pc", 16'(pc), 16'(note[38:26]));
      check("acc", 16'(acc), 16'(note[25:18]));
      check("zero", 16'(zero_flag), 16'(note[17]));
      check("flush", 16'(flush), 16'(note[0]));
      if (note[16])
        check("fwrite", 16'(fwrite), note[16:1]);
      else
        check("fwrite.we", 16'(fwrite.we), 16'h0000);
    end
  end

  task automatic do_reset();
    rstn <= 1'b0;
    insn_valid <= 1'b0;
    repeat (3) @(negedge mclk);
    check("pc reset", 16'(pc), 16'h0000);
    check("acc reset", 16'(acc), 16'h0000);
    check("flush reset", 16'({zero_flag, flush, fwrite.we}), 16'h0000);
    pc_m = 13'h0000;
    acc_m = 8'h00;
    z_m = 1'b0;
    rstn <= 1'b1;
    @(negedge mclk);
  endtask : do_reset

  // Presents one word, notes its expected outcome and plays out any flush slot.
  task automatic op(input logic [13:0] w);
    logic [7:0] fv, r;
    logic z, to_f, to_a, sk;
    logic [12:0] np;
    logic [4:0] lt;
    lt = 5'($random(seed));
    if (($random(seed) & 7) == 0)
    begin
      insn_valid <= 1'b0;
      insn <= 14'($random(seed));
      @(negedge mclk);
    end
    fv = fmem[w[6:0]];
    r = fv;
    z = z_m;
    to_f = 1'b0;
    to_a = 1'b0;
    sk = 1'b0;
    np = pc_m + 13'h0001;
    if (w[13:11] == exec_pkg::OP_BRANCH)
    begin
      np = {lt[4:3], w[10:0]};
      sk = 1'b1;
    end
    else if (w[13:10] == exec_pkg::OP_MOVE_LIT)
    begin
      r = w[7:0];
      to_a = 1'b1;
    end
    else if (w[13:8] == exec_pkg::OP_IOR_LIT)
    begin
      r = acc_m | w[7:0];
      z = (r == 8'h00);
      to_a = 1'b1;
    end
    else if (w[13:7] == exec_pkg::OP_MOVE_ACC)
    begin
      r = acc_m;
      to_f = 1'b1;
    end
    else if (w[13:8] inside {exec_pkg::OP_IOR_FILE, exec_pkg::OP_MOVE_FILE,
        exec_pkg::OP_INC_FILE, exec_pkg::OP_DEC_SKIP, exec_pkg::OP_INC_SKIP})
    begin
      case (w[13:8])
        exec_pkg::OP_IOR_FILE: r = acc_m | fv;
        exec_pkg::OP_INC_FILE: r = fv + 8'h01;
        exec_pkg::OP_DEC_SKIP: r = fv - 8'h01;
        exec_pkg::OP_INC_SKIP: r = fv + 8'h01;
        default: r = fv;
      endcase
      if (w[13:8] inside {exec_pkg::OP_DEC_SKIP, exec_pkg::OP_INC_SKIP})
        sk = (r == 8'h00);
      else
        z = (r == 8'h00);
      to_f = w[7];
      to_a = !w[7];
    end
    insn <= w;
    insn_valid <= 1'b1;
    pc_upper_latch <= lt;
    pc_m = np;
    if (to_a)
      acc_m = r;
    z_m = z;
    notes.push_back({np, acc_m, z, to_f, w[6:0], r, sk});
    @(posedge mclk);
    // Non-blocking, so the core still samples the old file value at this edge.
    if (to_f)
      fmem[w[6:0]] <= r;
    @(negedge mclk);
    if (sk)
    begin
      insn <= 14'($random(seed));
      @(negedge mclk);
      check("pc after flush", 16'(pc), 16'(pc_m));
      check("flush end", 16'({flush, fwrite.we}), 16'h0000);
    end
  endtask : op

  // Every operation class in turn, picked by a small index.
  function automatic logic [13:0] pick(input int s, input logic [13:0] r);
    case (s)
      0: pick = {exec_pkg::OP_IOR_FILE, r[7:0]};
      1: pick = {exec_pkg::OP_MOVE_FILE, r[7:0]};
      2: pick = {exec_pkg::OP_INC_FILE, r[7:0]};
      3: pick = {exec_pkg::OP_DEC_SKIP, r[7:0]};
      4: pick = {exec_pkg::OP_INC_SKIP, r[7:0]};
      5: pick = {exec_pkg::OP_MOVE_ACC, r[6:0]};
      6: pick = {exec_pkg::OP_BRANCH, r[10:0]};
      7: pick = {exec_pkg::OP_MOVE_LIT, r[9:0]};
      8: pick = {exec_pkg::OP_IOR_LIT, r[7:0]};
      default: pick = 14'h0000;
    endcase
  endfunction : pick

  // A hang ends the run through the same closing report.
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH timeout expected end seen none");
    give_verdict();
  end

  initial
  begin
    seed = 32'h26b2d845;
    rstn = 1'b0;
    insn_valid = 1'b0;
    insn = 14'h0000;
    pc_upper_latch = 5'h00;
    error_cnt = 0;
    samples_checked = 0;
    for (i = 0; i < 128; i++)
      fmem[i] = 8'($random(seed));
    fmem[5] = 8'h01;
    fmem[6] = 8'hFF;
    fmem[7] = 8'hFF;
    fmem[8] = 8'h00;
    do_reset();
    // Boundary cases first: zero results, skips, top address and full-width branch targets.
    op({exec_pkg::OP_MOVE_LIT, 10'h000});
    op({exec_pkg::OP_IOR_LIT, 8'h00});
    op({exec_pkg::OP_DEC_SKIP, 8'h85});
    op({exec_pkg::OP_INC_SKIP, 8'h06});
    op({exec_pkg::OP_INC_FILE, 8'h87});
    op({exec_pkg::OP_MOVE_FILE, 8'h88});
    op({exec_pkg::OP_MOVE_LIT, 10'h0A5});
    op({exec_pkg::OP_MOVE_ACC, 7'h7F});
    op({exec_pkg::OP_IOR_FILE, 8'h7F});
    op({exec_pkg::OP_BRANCH, 11'h7FF});
    op({exec_pkg::OP_BRANCH, 11'h000});
    for (i = 0; i < 400; i++)
      op(pick(i < 10 ? i : int'(($random(seed) & 32'h7FFF) % 10), 14'($random(seed))));
    // A reset in mid-run must return the core to its start state.
    do_reset();
    for (i = 0; i < 100; i++)
      op(pick(int'(($random(seed) & 32'h7FFF) % 10), 14'($random(seed))));
    repeat (2) @(negedge mclk);
    check("notes left", 16'(notes.size()), 16'h0000);
    give_verdict();
  end
endmodule : file_exec_core_test
`default_nettype wire
